// ===== design/irq_sel_pkg.sv
// Package: register map, field layouts and carrier types for the serial mask / battery route / soft irq block
package irq_sel_pkg;

  // Printed register offsets are not all multiples of four, so they are kept as word indices
  localparam logic [31:0] SER_MASK_IDX = 32'h0b000096;
  localparam logic [31:0] BATT_ROUTE_IDX = 32'h0b000098;
  localparam logic [31:0] SOFT_IRQ_IDX = 32'h0b00009a;
  localparam logic [31:0] EVT_STATUS_IDX = 32'h0b00009c;
  localparam logic [31:0] EVT_MASK_IDX = 32'h0b00009e;

  // Byte addresses are four times the index
  localparam logic [31:0] SER_MASK_ADDR = {SER_MASK_IDX[29:0], 2'b00};
  localparam logic [31:0] BATT_ROUTE_ADDR = {BATT_ROUTE_IDX[29:0], 2'b00};
  localparam logic [31:0] SOFT_IRQ_ADDR = {SOFT_IRQ_IDX[29:0], 2'b00};
  localparam logic [31:0] EVT_STATUS_ADDR = {EVT_STATUS_IDX[29:0], 2'b00};
  localparam logic [31:0] EVT_MASK_ADDR = {EVT_MASK_IDX[29:0], 2'b00};

  // Writable bits of each register; everything else is reserved and reads zero
  localparam logic [15:0] SER_MASK_WMASK = 16'h3fff;
  localparam logic [15:0] ONE_BIT_WMASK = 16'h0001;
  localparam logic [15:0] EVT_WMASK = 16'h0007;

  // Reset values
  localparam logic [15:0] SER_MASK_RESET = 16'h0000;
  localparam logic [15:0] ONE_BIT_RESET = 16'h0000;
  localparam logic [2:0] EVT_RESET = 3'h0;

  // Serial mask field positions
  localparam int DBG_RX_ERROR_EN = 13;
  localparam int DBG_RX_DONE_EN = 12;
  localparam int DBG_TX_DONE_EN = 11;
  localparam int BREAK_DETECT_EN = 10;
  localparam int FRAMING_ERROR_EN = 9;
  localparam int CHAR_RX_LOST_EN = 5;
  localparam int CHAR_RX_DONE_EN = 4;
  localparam int RX_DMA_PAGE2_EN = 3;
  localparam int RX_DMA_PAGE1_EN = 2;
  localparam int TX_DMA_PAGE2_EN = 1;
  localparam int TX_DMA_PAGE1_EN = 0;
  localparam int SER_SRC_W = 14;

  // Event status bit positions
  localparam int EVT_SERIAL = 0;
  localparam int EVT_BATTERY = 1;
  localparam int EVT_SOFT = 2;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_SER_MASK = 3'b001,
    SEL_BATT_ROUTE = 3'b010,
    SEL_SOFT_IRQ = 3'b011,
    SEL_EVT_STATUS = 3'b100,
    SEL_EVT_MASK = 3'b101
  } reg_sel_t;

  // Write request handed from the bus port to the register file
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

  // Address decode, used for writes, reads and responses
  function automatic reg_sel_t decode_addr(input logic [31:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == SER_MASK_ADDR) begin
      sel = SEL_SER_MASK;
    end else if (addr == BATT_ROUTE_ADDR) begin
      sel = SEL_BATT_ROUTE;
    end else if (addr == SOFT_IRQ_ADDR) begin
      sel = SEL_SOFT_IRQ;
    end else if (addr == EVT_STATUS_ADDR) begin
      sel = SEL_EVT_STATUS;
    end else if (addr == EVT_MASK_ADDR) begin
      sel = SEL_EVT_MASK;
    end
    return sel;
  endfunction

  // Byte-lane merge into a 16-bit register, keeping reserved bits at zero
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v & wmask;
  endfunction

endpackage

// ===== design/axil_port.sv
// AXI4-Lite slave front end: channel handshakes, write/read strobes toward the register file
module axil_port
  import irq_sel_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address and data
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register file side
  output logic wr_stb,
  output wr_req_t wr_req,
  output logic rd_stb,
  output logic [31:0] rd_addr,
  input wire logic [31:0] rd_data
);

  logic aw_held_r; // Address captured, waiting for data
  logic w_held_r; // Data captured, waiting for address

  // Write channels: either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_stb <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_req <= '0;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (awvalid && awready) begin
        wr_req.addr <= awaddr;
        awready <= 1'b0;
        aw_held_r <= 1'b1;
      end
      if (wvalid && wready) begin
        wr_req.data <= wdata;
        wr_req.strb <= wstrb;
        wready <= 1'b0;
        w_held_r <= 1'b1;
      end
      // Both halves present: commit and answer
      if (aw_held_r && w_held_r && !bvalid) begin
        wr_stb <= 1'b1;
        bvalid <= 1'b1;
        bresp <= (decode_addr(wr_req.addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      // Reopen only after the response is taken
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel: strobe one cycle, data the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_stb <= 1'b0;
      rd_addr <= 32'h0000_0000;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      rd_stb <= 1'b0;
      if (arvalid && arready) begin
        rd_addr <= araddr;
        arready <= 1'b0;
        rd_stb <= 1'b1;
      end
      if (rd_stb) begin
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= (decode_addr(rd_addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// ===== design/irq_gate.sv
// Per-bit enable gating of two source vectors, OR-combined into one registered request
module irq_gate #(
  parameter int N = 14
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Sources and enables
  input wire logic [N-1:0] src_a,
  input wire logic [N-1:0] src_b,
  input wire logic [N-1:0] enable,
  // Combined request
  output logic req
);

  // Refuse widths the logic cannot serve, at elaboration rather than at run time
  if (N < 1 || N > 16) begin : g_bad_n
    $error("irq_gate: N out of range");
  end

  logic [N-1:0] pass; // Enabled sources, one per bit

  // A source passes only when its raw level and enable are both one
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign pass[i] = (src_a[i] | src_b[i]) & enable[i];
  end

  // Registered OR so the request is glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= 1'b0;
    end else if (ce) begin
      req <= |pass;
    end
  end

endmodule

// ===== design/serial_irq_mask_nmi_select_softint.sv
// Serial second-level masks, battery interrupt routing and software interrupt, with AXI4-Lite access
//
// Our own choice: the AXI4-Lite interface to the registers.
module serial_irq_mask_nmi_select_softint
  import irq_sel_pkg::*;
#(
  parameter int SER_W = SER_SRC_W
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Raw interrupt sources
  input wire logic [SER_W-1:0] ser_raw,
  input wire logic [SER_W-1:0] dbg_ser_raw,
  input wire logic batt_low,
  // Processor requests
  output logic cpu_irq_line_zero,
  output logic cpu_nmi,
  // Block event interrupt
  output logic irq
);

  // The mask register has exactly fourteen usable bits; refused at elaboration
  if (SER_W != SER_SRC_W) begin : g_bad_width
    $error("serial width must match the mask register");
  end

  logic wr_stb; // One-cycle write commit
  wr_req_t wr_req; // Captured write
  logic rd_stb; // One-cycle read strobe
  logic [31:0] rd_addr; // Captured read address
  logic [31:0] rd_data; // Read mux result
  reg_sel_t wr_sel; // Decoded write target
  reg_sel_t rd_sel; // Decoded read target
  logic [15:0] ser_mask_r; // Serial enables
  logic [15:0] route_r; // Battery routing, bit zero only
  logic [15:0] soft_r; // Software interrupt, bit zero only
  logic [2:0] evt_status_r; // Sticky events
  logic [2:0] evt_mask_r; // Event enables
  logic [2:0] evt_nxt; // Next sticky value
  logic ser_req; // Gated serial request
  logic ser_req_prev_r; // For rising detect
  logic batt_prev_r; // For rising detect
  logic soft_set; // Software writes one
  logic soft_wr; // Write to soft register with byte lane zero

  // Bus slave front end
  axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_stb(wr_stb),
    .wr_req(wr_req),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign wr_sel = decode_addr(wr_req.addr);
  assign rd_sel = decode_addr(rd_addr);
  // Only byte lane zero carries the soft bit
  assign soft_wr = wr_stb && (wr_sel == SEL_SOFT_IRQ) && wr_req.strb[0];
  assign soft_set = soft_wr && wr_req.data[0];

  // Serial mask register; same enables serve both serial units
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_mask_r <= SER_MASK_RESET;
    end else if (ce && wr_stb && wr_sel == SEL_SER_MASK) begin
      ser_mask_r <= merge16(ser_mask_r, wr_req.data, wr_req.strb, SER_MASK_WMASK);
    end
  end

  // Battery routing bit, NMI after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r <= ONE_BIT_RESET;
    end else if (ce && wr_stb && wr_sel == SEL_BATT_ROUTE) begin
      route_r <= merge16(route_r, wr_req.data, wr_req.strb, ONE_BIT_WMASK);
    end
  end

  // Software interrupt: set only by software writes, cleared by a software write of zero or by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_r <= ONE_BIT_RESET;
    end else if (ce && soft_wr) begin
      soft_r <= {15'h0000, wr_req.data[0]};
    end
  end

  // Event mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_r <= EVT_RESET;
    end else if (ce && wr_stb && wr_sel == SEL_EVT_MASK) begin
      evt_mask_r <= wr_req.data[2:0];
    end
  end

  // Serial gating: raw AND enable per bit, OR over both units
  irq_gate #(
    .N(SER_W)
  ) u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .src_a(ser_raw),
    .src_b(dbg_ser_raw),
    .enable(ser_mask_r[SER_W-1:0]),
    .req(ser_req)
  );

  // Processor request lines, each straight from a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq_line_zero <= 1'b0;
      cpu_nmi <= 1'b0;
    end else if (ce) begin
      cpu_irq_line_zero <= ser_req | soft_r[0] | (batt_low & route_r[0]);
      cpu_nmi <= batt_low & ~route_r[0];
    end
  end

  // Edge history for the event detectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_req_prev_r <= 1'b0;
      batt_prev_r <= 1'b0;
    end else if (ce) begin
      ser_req_prev_r <= ser_req;
      batt_prev_r <= batt_low;
    end
  end

  // Sticky events; a set in the clearing read's cycle survives
  always_comb begin
    evt_nxt = evt_status_r;
    if (rd_stb && rd_sel == SEL_EVT_STATUS) begin
      evt_nxt = EVT_RESET;
    end
    if (ser_req && !ser_req_prev_r) begin
      evt_nxt[EVT_SERIAL] = 1'b1;
    end
    if (batt_low && !batt_prev_r) begin
      evt_nxt[EVT_BATTERY] = 1'b1;
    end
    if (soft_set) begin
      evt_nxt[EVT_SOFT] = 1'b1;
    end
  end

  // Status register and level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_r <= EVT_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      evt_status_r <= evt_nxt;
      irq <= |(evt_nxt & evt_mask_r);
    end
  end

  // Read mux; reserved bits come back zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_sel == SEL_SER_MASK) begin
      rd_data = {16'h0000, ser_mask_r & SER_MASK_WMASK};
    end else if (rd_sel == SEL_BATT_ROUTE) begin
      rd_data = {16'h0000, route_r & ONE_BIT_WMASK};
    end else if (rd_sel == SEL_SOFT_IRQ) begin
      rd_data = {16'h0000, soft_r & ONE_BIT_WMASK};
    end else if (rd_sel == SEL_EVT_STATUS) begin
      rd_data = {29'h0000_0000, evt_status_r};
    end else if (rd_sel == SEL_EVT_MASK) begin
      rd_data = {29'h0000_0000, evt_mask_r};
    end
  end

  // Checks on the documented behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_route_reset;
    $rose(aresetn) |-> (route_r[0] == 1'b0 && !cpu_nmi && !cpu_irq_line_zero);
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("route bit not zero after reset");

  property p_mask_reset;
    $rose(aresetn) |-> (ser_mask_r == 16'h0000);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("serial mask not cleared by reset");

  property p_reserved_zero;
    (ser_mask_r[15:14] == 2'b00) && (route_r[15:1] == 15'h0000) && (soft_r[15:1] == 15'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit became set");

  property p_batt_nmi;
    (ce && batt_low && !route_r[0]) |=> (cpu_nmi && $past(route_r[0]) == 1'b0);
  endproperty
  a_batt_nmi: assert property (p_batt_nmi) else $error("battery event not sent as NMI");

  property p_batt_line0;
    (ce && batt_low && route_r[0]) |=> (cpu_irq_line_zero && !cpu_nmi);
  endproperty
  a_batt_line0: assert property (p_batt_line0) else $error("battery event not sent on line zero");

  property p_soft_set_cause;
    $rose(soft_r[0]) |-> $past(soft_set);
  endproperty
  a_soft_set_cause: assert property (p_soft_set_cause) else $error("soft irq set without write");

  property p_soft_hold;
    (soft_r[0] && !(ce && soft_wr && !wr_req.data[0])) |=> soft_r[0];
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft irq dropped without clear");

  property p_soft_line0;
    (ce && soft_r[0]) |=> cpu_irq_line_zero;
  endproperty
  a_soft_line0: assert property (p_soft_line0) else $error("soft irq missing on line zero");

  property p_gate_pass;
    (ce && |((ser_raw | dbg_ser_raw) & ser_mask_r[SER_W-1:0])) ##1 ce |=> cpu_irq_line_zero;
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("enabled serial source not passed");

  property p_gate_block;
    (ce && ((ser_raw | dbg_ser_raw) & ser_mask_r[SER_W-1:0]) == '0 && !soft_r[0] && !batt_low)[*2]
      |=> !cpu_irq_line_zero;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("masked source reached line zero");

  // Request lines and control bits move only for their own causes
  property p_nmi_cause;
    $rose(cpu_nmi) |-> $past(batt_low && !route_r[0]);
  endproperty
  a_nmi_cause: assert property (p_nmi_cause) else $error("NMI raised without battery event");

  property p_nmi_drop;
    (ce && !batt_low) |=> !cpu_nmi;
  endproperty
  a_nmi_drop: assert property (p_nmi_drop) else $error("NMI held after battery event ended");

  property p_route_write_only;
    $rose(route_r[0]) |-> $past(wr_stb && wr_sel == SEL_BATT_ROUTE);
  endproperty
  a_route_write_only: assert property (p_route_write_only) else $error("route bit moved without a write");

  // Reset only clears the mask, so any newly opened bit needs a write behind it
  property p_mask_write_only;
    (ser_mask_r & ~$past(ser_mask_r)) != 16'h0000 |-> $past(wr_stb && wr_sel == SEL_SER_MASK);
  endproperty
  a_mask_write_only: assert property (p_mask_write_only) else $error("mask bit opened without a write");

  property p_soft_clear;
    (ce && soft_wr && !wr_req.data[0]) |=> !soft_r[0];
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft irq not cleared by write of zero");

  property p_line0_quiet;
    (ce && !ser_req && !soft_r[0] && !batt_low) |=> !cpu_irq_line_zero;
  endproperty
  a_line0_quiet: assert property (p_line0_quiet) else $error("line zero raised with no source");

endmodule

// ===== test/cpu_core_model.sv
// Processor core stand-in that watches the two interrupt request lines
module cpu_core_model
  import irq_sel_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the block
  input wire logic line_zero,
  input wire logic nmi,
  // Observed request counts
  output logic [7:0] nmi_edges,
  output logic [7:0] line0_edges
);
  timeunit 1ns;
  timeprecision 100ps;
  logic nmi_prev_r; // Last sampled NMI level
  logic line0_prev_r; // Last sampled line zero level

  // Count rising edges only: the core takes an NMI once per assertion, a held level is one event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev_r <= 1'b0;
      line0_prev_r <= 1'b0;
      nmi_edges <= 8'h00;
      line0_edges <= 8'h00;
    end else begin
      nmi_prev_r <= nmi;
      line0_prev_r <= line_zero;
      // New NMI request
      if (nmi && !nmi_prev_r) begin
        nmi_edges <= nmi_edges + 8'h01;
      end
      // New line zero request
      if (line_zero && !line0_prev_r) begin
        line0_edges <= line0_edges + 8'h01;
      end
    end
  end
endmodule

// ===== test/test_serial_irq_mask_nmi_select_softint.sv
// Self-checking bench for the serial mask, battery routing and software interrupt block
module test_serial_irq_mask_nmi_select_softint
  import irq_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  // Interrupt side
  logic [13:0] ser_raw, dbg_ser_raw;
  logic batt_low, cpu_irq_line_zero, cpu_nmi, irq;
  logic [7:0] nmi_edges, line0_edges, l0_base; // Core request counts and a snapshot
  // Bookkeeping
  int errors, n_tests, seed;
  logic [31:0] rnd_a, rnd_b, rnd_c;
  logic [31:0] addrs [3] = '{SER_MASK_ADDR, BATT_ROUTE_ADDR, SOFT_IRQ_ADDR};
  logic [31:0] wmask [3] = '{32'h3fff, 32'h1, 32'h1};

  // 100 MHz clock
  always #5 aclk = ~aclk;

  serial_irq_mask_nmi_select_softint #(.SER_W(14)) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .ser_raw(ser_raw), .dbg_ser_raw(dbg_ser_raw), .batt_low(batt_low),
    .cpu_irq_line_zero(cpu_irq_line_zero), .cpu_nmi(cpu_nmi), .irq(irq));

  cpu_core_model core_u (.aclk(aclk), .aresetn(aresetn), .line_zero(cpu_irq_line_zero), .nmi(cpu_nmi),
    .nmi_edges(nmi_edges), .line0_edges(line0_edges));

  // Expected line zero from serial sources alone
  function automatic logic exp_line0(input logic [13:0] m, input logic [13:0] s, input logic [13:0] g);
    return |((s | g) & m);
  endfunction

  // One comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read: address held until taken, then wait for data
  task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Program the mask, drive both units' sources, check the gated request
  task automatic apply(input logic [13:0] m, input logic [13:0] s, input logic [13:0] g);
    logic [1:0] wr;
    axi_write(SER_MASK_ADDR, {18'h0, m}, 4'hf, wr);
    ser_raw <= s;
    dbg_ser_raw <= g;
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_irq_line_zero}, {31'h0, exp_line0(m, s, g)});
  endtask

  // Verdict, printed once
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run of roughly seven hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    seed = 72066;
    errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, batt_low} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    ser_raw = 14'h0;
    dbg_ser_raw = 14'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Everything masked, NMI routing, soft bit clear after reset
    for (int k = 0; k < 3; k++) begin
      axi_read(addrs[k], d, r);
      check(d, 32'h0);
    end
    // Reserved bits read zero even when written with ones
    for (int k = 0; k < 3; k++) begin
      axi_write(addrs[k], 32'hffffffff, 4'hf, r);
      axi_read(addrs[k], d, r);
      check(d, wmask[k]);
      axi_write(addrs[k], 32'h0, 4'hf, r);
    end
    // Unmapped place answers with an error and zero data
    axi_write(32'h00000004, 32'h1, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(32'h00000004, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    // Walk every mask bit over each unit, then the inverse mask
    for (int i = 0; i < SER_SRC_W; i++) begin
      apply(14'h1 << i, 14'h1 << i, 14'h0);
      apply(14'h1 << i, 14'h0, 14'h1 << i);
      apply(~(14'h1 << i), 14'h1 << i, 14'h1 << i);
    end
    // Random masks and sources
    repeat (30) begin
      rnd_a = $random(seed);
      rnd_b = $random(seed);
      rnd_c = $random(seed);
      apply(rnd_a[13:0], rnd_b[13:0] & rnd_c[13:0], rnd_c[13:0]);
    end
    // Low battery delivered as NMI by default
    axi_write(SER_MASK_ADDR, 32'h0, 4'hf, r);
    ser_raw <= 14'h3fff;
    dbg_ser_raw <= 14'h3fff;
    batt_low <= 1'b1;
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_nmi}, 32'h1);
    check({31'h0, cpu_irq_line_zero}, 32'h0);
    check({24'h0, nmi_edges}, 32'h1);
    // Routed to line zero after writing one
    axi_write(BATT_ROUTE_ADDR, 32'h1, 4'hf, r);
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_nmi}, 32'h0);
    check({31'h0, cpu_irq_line_zero}, 32'h1);
    axi_write(BATT_ROUTE_ADDR, 32'h0, 4'hf, r);
    batt_low <= 1'b0;
    // Software interrupt set, held, cleared; open the soft event to the block interrupt
    axi_read(EVT_STATUS_ADDR, d, r);
    axi_write(EVT_MASK_ADDR, 32'h0, 4'hf, r);
    l0_base = line0_edges;
    axi_write(SOFT_IRQ_ADDR, 32'h1, 4'h1, r);
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_irq_line_zero}, 32'h1);
    check({24'h0, line0_edges}, {24'h0, l0_base + 8'h01});
    check({31'h0, irq}, 32'h0);
    repeat (50) @(posedge aclk);
    check({31'h0, cpu_irq_line_zero}, 32'h1);
    axi_write(EVT_MASK_ADDR, 32'h4, 4'hf, r);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    axi_read(EVT_STATUS_ADDR, d, r);
    check(d & 32'h4, 32'h4);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    axi_write(SOFT_IRQ_ADDR, 32'h0, 4'h1, r);
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_irq_line_zero}, 32'h0);
    // Clock enable low freezes the request lines; release lets the event through
    ce <= 1'b0;
    batt_low <= 1'b1;
    repeat (4) @(posedge aclk);
    check({31'h0, cpu_nmi}, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    check({31'h0, cpu_nmi}, 32'h1);
    batt_low <= 1'b0;
    // Reset in mid-run: masks closed, NMI routing, soft bit clear again
    axi_write(SER_MASK_ADDR, 32'h3fff, 4'hf, r);
    axi_write(BATT_ROUTE_ADDR, 32'h1, 4'hf, r);
    axi_write(SOFT_IRQ_ADDR, 32'h1, 4'hf, r);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 3; k++) begin
      axi_read(addrs[k], d, r);
      check(d, 32'h0);
    end
    tally_and_finish();
  end
endmodule
